/* rtl/pwc_config_bank.sv */
/*
 Port drive, stop-mode wake-up and watchdog mode register bank.
 Assumes a synchronous bank-F register port from the core, a recovery
 event pulse from the wake-up logic and a power-on indication.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pwc_defines.svh"

module pwc_config_bank
    import pwc_pkg::*;
#(
    parameter int WINDOW_CLKS = `PWC_WD_WINDOW
)
(
    // Clock, reset, enable
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic enable_i,
    // Power-on indication, clears the recovery flag
    input wire logic power_on_i,
    // Restart of the watchdog write window
    input wire logic window_restart_i,
    // Stop-mode recovery event from wake-up logic
    input wire logic recovery_event_i,
    // Bank-F register port
    input wire logic [3:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    // Port 2 wake sensing
    input wire logic [7:0] port2_pin_i,
    input wire logic [7:0] port2_out_i,
    input wire logic [7:0] port2_dir_out_i,
    output logic [7:0] port2_wake_sense_o,
    // Port drive options
    output pwc_drive_s drive_o,
    // Clock divider
    output logic clk_div2_o,
    // Wake-up logic settings
    output logic wake_level_high_o,
    output logic wake_delay_o,
    output logic [2:0] wake_src_1_o,
    output logic [1:0] wake_src_2_o,
    // Watchdog settings
    output pwc_wdog_s wdog_o,
    output logic wdog_locked_o
);

    // Stored bits
    logic [7:0] port_drive_config; // Full byte, reserved bits kept as written
    logic [6:0] wake_cfg_1; // Writable bits 6..0 of first register
    logic wake_flag; // Recovery flag, bit 7
    logic [1:0] wake_cfg_2; // Source bits of second register
    logic [4:0] watchdog_mode; // Bits 4..0; upper bits read as zero anyway
    pwc_win_e win_state; // Watchdog write window
    logic [6:0] win_count; // Clocks since window opened

    // Decode strobes
    logic wr_port, wr_w1, wr_w2, wr_wd;
    always_comb
    begin
        wr_port = 1'b0;
        wr_w1 = 1'b0;
        wr_w2 = 1'b0;
        wr_wd = 1'b0;
        if (reg_wr_i && reg_addr_i == `PWC_OFS_PORT_CFG)
        begin
            wr_port = 1'b1;
        end
        else if (reg_wr_i && reg_addr_i == `PWC_OFS_WAKE_1)
        begin
            wr_w1 = 1'b1;
        end
        else if (reg_wr_i && reg_addr_i == `PWC_OFS_WAKE_2)
        begin
            wr_w2 = 1'b1;
        end
        else if (reg_wr_i && reg_addr_i == `PWC_OFS_WDOG)
        begin
            wr_wd = 1'b1;
        end
    end

    // Port configuration register
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            port_drive_config <= `PWC_RST_PORT_CFG;
        end
        else if (enable_i && wr_port)
        begin
            port_drive_config <= reg_wdata_i;
        end
    end

    // Wake recovery register 1, writable part
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            wake_cfg_1 <= `PWC_RST_WAKE_1;
        end
        else if (enable_i && wr_w1)
        begin
            wake_cfg_1 <= reg_wdata_i[6:0];
        end
    end

    // Recovery flag survives ordinary resets; only power-on clears it
    always_ff @(posedge clock_i)
    begin
        if (enable_i)
        begin
            if (recovery_event_i)
            begin
                wake_flag <= 1'b1;
            end
            else if (power_on_i)
            begin
                wake_flag <= 1'b0;
            end
        end
    end

    // Wake recovery register 2
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            wake_cfg_2 <= `PWC_RST_WAKE_2;
        end
        else if (enable_i && wr_w2)
        begin
            wake_cfg_2 <= reg_wdata_i[1:0];
        end
    end

    // Write window: opens on reset, window restart or recovery, locks after set count
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            win_state <= PWC_OPEN;
            win_count <= 7'h00;
        end
        else if (enable_i)
        begin
            if (window_restart_i || recovery_event_i)
            begin
                win_state <= PWC_OPEN;
                win_count <= 7'h00;
            end
            else
            begin
                case (win_state)
                    PWC_OPEN:
                    begin
                        if (win_count == 7'(WINDOW_CLKS - 1))
                        begin
                            win_state <= PWC_LOCKED;
                        end
                        else
                        begin
                            win_count <= win_count + 7'h01;
                        end
                    end
                    PWC_LOCKED:
                    begin
                        win_state <= PWC_LOCKED;
                    end
                    default:
                    begin
                        win_state <= PWC_LOCKED;
                    end
                endcase
            end
        end
    end

    // Watchdog mode register, guarded by the window
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            watchdog_mode <= `PWC_RST_WDOG;
        end
        else if (enable_i && wr_wd && win_state == PWC_OPEN)
        begin
            watchdog_mode <= reg_wdata_i[4:0];
        end
    end

    // Read path: only the flag is readable, all else reads zero
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            reg_rdata_o <= 8'h00;
        end
        else if (enable_i)
        begin
            if (reg_rd_i && reg_addr_i == `PWC_OFS_WAKE_1)
            begin
                reg_rdata_o <= {wake_flag, 7'h00};
            end
            else
            begin
                reg_rdata_o <= 8'h00;
            end
        end
    end

    // Registered outputs to drivers, divider, wake logic, watchdog
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            drive_o <= '0;
            clk_div2_o <= 1'b1;
            wake_level_high_o <= 1'b0;
            wake_delay_o <= 1'b0;
            wake_src_1_o <= 3'h0;
            wake_src_2_o <= 2'h0;
            wdog_o <= '0;
            wdog_locked_o <= 1'b0;
            port2_wake_sense_o <= 8'h00;
        end
        else if (enable_i)
        begin
            drive_o.cmp_to_port3 <= port_drive_config[`PWC_PC_CMP];
            drive_o.port0_push_pull <= port_drive_config[`PWC_PC_P0_PP];
            drive_o.port0_standard <= port_drive_config[`PWC_PC_P0_STD];
            drive_o.port2_standard <= port_drive_config[`PWC_PC_P2_STD];
            drive_o.port3_standard <= port_drive_config[`PWC_PC_P3_STD];
            drive_o.osc_standard <= port_drive_config[`PWC_PC_OSC_STD];
            clk_div2_o <= ~wake_cfg_1[`PWC_W1_CLK_FULL];
            wake_level_high_o <= wake_cfg_1[`PWC_W1_LEVEL];
            wake_delay_o <= wake_cfg_1[`PWC_W1_DELAY];
            wake_src_1_o <= wake_cfg_1[`PWC_W1_SRC_HI:`PWC_W1_SRC_LO];
            wake_src_2_o <= wake_cfg_2;
            wdog_o.clk_from_xin <= watchdog_mode[`PWC_WD_XIN];
            wdog_o.run_in_stop <= watchdog_mode[`PWC_WD_STOP];
            wdog_o.run_in_halt <= watchdog_mode[`PWC_WD_HALT];
            case (watchdog_mode[`PWC_WD_TAP_HI:0])
                2'b00: wdog_o.timeout_sclk <= `PWC_TMO_TAP_0;
                2'b01: wdog_o.timeout_sclk <= `PWC_TMO_TAP_1;
                2'b10: wdog_o.timeout_sclk <= `PWC_TMO_TAP_2;
                default: wdog_o.timeout_sclk <= `PWC_TMO_TAP_3;
            endcase
            wdog_locked_o <= (win_state == PWC_LOCKED);
            // Output pins feed back their driven level to the wake logic
            port2_wake_sense_o <= (port2_dir_out_i & port2_out_i)
                | (~port2_dir_out_i & port2_pin_i);
        end
    end

    // Checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (rst_i);

    port_reset_a: assert property ($rose(!rst_i) |-> port_drive_config == 8'hFE)
        else $error("port config reset value wrong");
    cmp_route_a: assert property (enable_i && wr_port ##1 enable_i
        |=> drive_o.cmp_to_port3 == $past(reg_wdata_i[0], 2))
        else $error("comparator routing not following write");
    p0_style_a: assert property (enable_i |=> drive_o.port0_push_pull
        == $past(port_drive_config[2]))
        else $error("port 0 style mismatch");
    emi_drive_a: assert property (enable_i |=> drive_o.port2_standard
        == $past(port_drive_config[5]) && drive_o.port3_standard
        == $past(port_drive_config[6]) && drive_o.osc_standard
        == $past(port_drive_config[7]) && drive_o.port0_standard
        == $past(port_drive_config[3]))
        else $error("low emission drive mismatch");
    flag_set_a: assert property (enable_i && recovery_event_i |=> wake_flag)
        else $error("recovery flag not set");
    flag_hold_a: assert property (wake_flag && !power_on_i |=> wake_flag)
        else $error("recovery flag lost without power-on");
    clk_div_a: assert property (enable_i |=> clk_div2_o
        == !$past(wake_cfg_1[1]))
        else $error("clock divide mismatch");
    tap_map_a: assert property (enable_i && watchdog_mode[1:0] == 2'b11
        |=> wdog_o.timeout_sclk == `PWC_TMO_TAP_3)
        else $error("watchdog tap wrong");
    wd_lock_a: assert property (win_state == PWC_LOCKED && !window_restart_i
        && !recovery_event_i |=> $stable(watchdog_mode))
        else $error("watchdog mode changed while locked");
    win_len_a: assert property (enable_i && window_restart_i ##1
        (enable_i && !window_restart_i && !recovery_event_i) [*8]
        |-> win_state == PWC_OPEN)
        else $error("window closed too early");
    sense_a: assert property (enable_i && port2_dir_out_i[0]
        |=> port2_wake_sense_o[0] == $past(port2_out_i[0]))
        else $error("output pin level not sensed");

    // Anything but the flag location must read as zero
    rd_zero_a: assert property (enable_i && !(reg_rd_i && reg_addr_i == `PWC_OFS_WAKE_1)
        |=> reg_rdata_o == 8'h00)
        else $error("write-only location read back nonzero");
    // Flag location shows the stored flag one cycle after the read
    flag_read_a: assert property (enable_i && reg_rd_i && reg_addr_i == `PWC_OFS_WAKE_1
        |=> reg_rdata_o[`PWC_W1_FLAG] == $past(wake_flag))
        else $error("recovery flag read back wrong");
    wake_cfg_a: assert property (enable_i |=> wake_level_high_o
        == $past(wake_cfg_1[`PWC_W1_LEVEL]) && wake_delay_o
        == $past(wake_cfg_1[`PWC_W1_DELAY]))
        else $error("wake level or delay mismatch");
    // Watchdog defaults must be in place as soon as reset lets go
    wd_reset_a: assert property ($rose(!rst_i) |-> watchdog_mode == `PWC_RST_WDOG)
        else $error("watchdog mode reset value wrong");
    // Clock enable low must hold the port, first wake and watchdog settings and the drive outputs
    state_freeze_a: assert property (!enable_i |=> $stable(port_drive_config)
        && $stable(watchdog_mode) && $stable(wake_cfg_1) && $stable(drive_o))
        else $error("state moved while clock enable low");

    lock_c: cover property (win_state == PWC_OPEN ##1 win_state == PWC_LOCKED);
    freeze_c: cover property (!enable_i && wr_port);
    flag_c: cover property (recovery_event_i ##1 wake_flag);
    late_wr_c: cover property (wr_wd && win_state == PWC_LOCKED);
    cmp_c: cover property (drive_o.cmp_to_port3);

endmodule
`default_nettype wire

/* rtl/pwc_defines.svh */
/*
 Constants for the port, wake and watchdog configuration bank.
 Assumes inclusion by bare name from the design and bench files.
*/
`ifndef PWC_DEFINES_SVH
`define PWC_DEFINES_SVH

// Register offsets within the expanded bank
`define PWC_OFS_PORT_CFG 4'h0
`define PWC_OFS_WAKE_1 4'hB
`define PWC_OFS_WAKE_2 4'hD
`define PWC_OFS_WDOG 4'hF

// Reset values
`define PWC_RST_PORT_CFG 8'hFE
`define PWC_RST_WAKE_1 7'h00
`define PWC_RST_WAKE_2 2'h0
`define PWC_RST_WDOG 5'h0D

// Port configuration fields
`define PWC_PC_CMP 0
`define PWC_PC_P0_PP 2
`define PWC_PC_P0_STD 3
`define PWC_PC_P2_STD 5
`define PWC_PC_P3_STD 6
`define PWC_PC_OSC_STD 7

// Wake recovery register 1 fields
`define PWC_W1_CLK_FULL 1
`define PWC_W1_SRC_LO 2
`define PWC_W1_SRC_HI 4
`define PWC_W1_DELAY 5
`define PWC_W1_LEVEL 6
`define PWC_W1_FLAG 7

// Watchdog mode fields
`define PWC_WD_TAP_HI 1
`define PWC_WD_HALT 2
`define PWC_WD_STOP 3
`define PWC_WD_XIN 4

// Write window length in system clocks
`define PWC_WD_WINDOW 64

// Watchdog timeouts in system clocks, one per tap code
`define PWC_TMO_TAP_0 12'h080
`define PWC_TMO_TAP_1 12'h100
`define PWC_TMO_TAP_2 12'h200
`define PWC_TMO_TAP_3 12'h800

`endif

/* rtl/pwc_pkg.sv */
/*
 Types for the port, wake and watchdog configuration bank.
 Assumes the defines header is compiled alongside.
*/
package pwc_pkg;

    // Decoded port drive options
    typedef struct packed {
        logic cmp_to_port3;
        logic port0_push_pull;
        logic port0_standard;
        logic port2_standard;
        logic port3_standard;
        logic osc_standard;
    } pwc_drive_s;

    // Decoded watchdog settings
    typedef struct packed {
        logic clk_from_xin;
        logic run_in_stop;
        logic run_in_halt;
        logic [11:0] timeout_sclk;
    } pwc_wdog_s;

    // Write window state
    typedef enum logic [1:0] {
        PWC_OPEN = 2'b01,
        PWC_LOCKED = 2'b10
    } pwc_win_e;

endpackage

/* sim/pwc_config_bank_tb.sv */
/*
 Self-checking bench for the port, wake and watchdog configuration bank.
 Assumes the package, the defines header and the design are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "pwc_defines.svh"

module pwc_config_bank_tb;
    import pwc_pkg::*;

    // Expected result, the cycle count at which it must show, and what is watched
    typedef struct {int id; logic [15:0] exp; int due;} pwc_note_s;

    // Stimulus, all given a value at time zero
    logic clock_i = 1'b0;
    logic rst_i = 1'b1;
    logic enable_i = 1'b1;
    logic power_on_i = 1'b1;
    logic window_restart_i = 1'b0;
    logic recovery_event_i = 1'b0;
    logic [3:0] reg_addr_i = 4'h0;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic [7:0] port2_pin_i = 8'h00;
    logic [7:0] port2_out_i = 8'h00;
    logic [7:0] port2_dir_out_i = 8'h00;
    // Observed outputs
    logic [7:0] reg_rdata_o;
    logic [7:0] port2_wake_sense_o;
    pwc_drive_s drive_o;
    pwc_wdog_s wdog_o;
    logic clk_div2_o, wake_level_high_o, wake_delay_o, wdog_locked_o;
    logic [2:0] wake_src_1_o;
    logic [1:0] wake_src_2_o;
    // Bookkeeping
    pwc_note_s q[$];
    string nm[8] = '{"rdata", "drive", "clk_div2", "wake_cfg", "wdog", "locked", "sense",
        "wake_src_2"};
    int cyc = 0;
    int n_fail = 0;
    int num_checks = 0;
    integer seed = 32'h714a_166d;

    // Short window keeps the lock test quick
    pwc_config_bank #(.WINDOW_CLKS(8)) dut_u (.clock_i(clock_i), .rst_i(rst_i),
        .enable_i(enable_i), .power_on_i(power_on_i), .window_restart_i(window_restart_i),
        .recovery_event_i(recovery_event_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
        .reg_rd_i(reg_rd_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
        .port2_pin_i(port2_pin_i), .port2_out_i(port2_out_i),
        .port2_dir_out_i(port2_dir_out_i), .port2_wake_sense_o(port2_wake_sense_o),
        .drive_o(drive_o), .clk_div2_o(clk_div2_o), .wake_level_high_o(wake_level_high_o),
        .wake_delay_o(wake_delay_o), .wake_src_1_o(wake_src_1_o),
        .wake_src_2_o(wake_src_2_o), .wdog_o(wdog_o), .wdog_locked_o(wdog_locked_o));

    // 100 ns period
    always #50 clock_i = ~clock_i;

    // Cycle count and hang guard
    always @(posedge clock_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 3000)
        begin
            n_fail++;
            give_verdict();
        end
    end

    // Picks the watched output, widened to one compare width
    function automatic logic [15:0] seen(input int id);
        case (id)
            0: seen = {8'h00, reg_rdata_o};
            1: seen = {10'h000, drive_o};
            2: seen = {15'h0000, clk_div2_o};
            3: seen = {11'h000, wake_level_high_o, wake_delay_o, wake_src_1_o};
            4: seen = {1'b0, wdog_o};
            5: seen = {15'h0000, wdog_locked_o};
            6: seen = {8'h00, port2_wake_sense_o};
            default: seen = {14'h0000, wake_src_2_o};
        endcase
    endfunction

    // Watchdog tap to system clock count
    function automatic logic [11:0] tmo(input logic [1:0] t);
        tmo = (t == 2'b11) ? 12'h800 : (12'h080 << t);
    endfunction

    task automatic check(input string what, input logic [15:0] e, input logic [15:0] s);
        num_checks++;
        if (s !== e)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", what, e, s);
        end
    endtask

    // Monitor samples well after the edge, away from the driver's falling edge
    always @(posedge clock_i)
    begin
        pwc_note_s n;
        #20;
        while (q.size() > 0 && q[0].due <= cyc)
        begin
            n = q.pop_front();
            check(nm[n.id], n.exp, seen(n.id));
        end
    end

    task automatic tick();
        @(negedge clock_i);
    endtask

    // Note due after the next rising edge; all notes use one delay so the queue stays ordered
    task automatic expect_v(input int id, input logic [15:0] e);
        q.push_back('{id, e, cyc + 1});
    endtask

    // Write strobe for one cycle, then two idle cycles for the outputs to settle
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        reg_addr_i = a;
        reg_wdata_i = d;
        reg_wr_i = 1'b1;
        tick();
        reg_wr_i = 1'b0;
        repeat (2) tick();
    endtask

    // Read: data for one cycle, zero in the next
    task automatic rd(input logic [3:0] a, input logic [15:0] e);
        reg_addr_i = a;
        reg_rd_i = 1'b1;
        expect_v(0, e);
        tick();
        reg_rd_i = 1'b0;
        expect_v(0, 16'h0000);
        tick();
    endtask

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        logic [7:0] d;
        logic [15:0] w;
        logic [7:0] e;
        repeat (5) tick();
        rst_i = 1'b0;
        power_on_i = 1'b0;
        expect_v(1, 16'h001f);
        expect_v(2, 16'h0001);
        expect_v(4, 16'h3100);
        expect_v(5, 16'h0000);
        tick();
        // Every watchdog tap, each in a freshly opened window
        for (int i = 0; i < 4; i++)
        begin
            window_restart_i = 1'b1;
            tick();
            window_restart_i = 1'b0;
            d = {3'b000, 5'($random(seed))};
            d[1:0] = i[1:0];
            wr(`PWC_OFS_WDOG, d);
            w = {1'b0, d[4:2], tmo(d[1:0])};
            expect_v(4, w);
            expect_v(5, 16'h0000);
        end
        // Window runs out, then a write must be ignored
        repeat (10) tick();
        expect_v(5, 16'h0001);
        wr(`PWC_OFS_WDOG, 8'h10);
        expect_v(4, w);
        // Port drive options, first with all option bits clear
        for (int i = 0; i < 6; i++)
        begin
            d = (i == 0) ? 8'h12 : (8'($random(seed)) | 8'h12 | 8'(i & 1));
            wr(`PWC_OFS_PORT_CFG, d);
            expect_v(1, {10'h000, d[0], d[2], d[3], d[5], d[6], d[7]});
        end
        // Frozen clock enable and an unmapped offset change nothing
        enable_i = 1'b0;
        wr(`PWC_OFS_PORT_CFG, ~d | 8'h12);
        enable_i = 1'b1;
        wr(4'h3, ~d | 8'h12);
        expect_v(1, {10'h000, d[0], d[2], d[3], d[5], d[6], d[7]});
        // Wake-up settings and clock divide
        for (int i = 0; i < 4; i++)
        begin
            wr(`PWC_OFS_WAKE_2, 8'($random(seed)));
            expect_v(7, {14'h0000, reg_wdata_i[1:0]});
            d = 8'($random(seed));
            // Both divide settings are seen whatever the seed gives
            d[1] = i[0];
            wr(`PWC_OFS_WAKE_1, d);
            wr(`PWC_OFS_WAKE_2, 8'h00);
            expect_v(3, {11'h000, d[6:2]});
            expect_v(2, {15'h0000, ~d[1]});
            expect_v(7, 16'h0000);
        end
        // Write-only places read as zero, flag still clear
        rd(`PWC_OFS_WAKE_1, 16'h0000);
        rd(`PWC_OFS_PORT_CFG, 16'h0000);
        rd(`PWC_OFS_WAKE_2, 16'h0000);
        rd(`PWC_OFS_WDOG, 16'h0000);
        // Recovery sets the flag and reopens the watchdog window
        recovery_event_i = 1'b1;
        tick();
        recovery_event_i = 1'b0;
        tick();
        expect_v(5, 16'h0000);
        rd(`PWC_OFS_WAKE_1, 16'h0080);
        wr(`PWC_OFS_WDOG, 8'h1c);
        expect_v(4, 16'h7080);
        // Let the note be looked at before reset clears the outputs
        tick();
        // Plain reset keeps the flag, only power-on clears it
        rst_i = 1'b1;
        tick();
        rst_i = 1'b0;
        expect_v(1, 16'h001f);
        expect_v(2, 16'h0001);
        expect_v(4, 16'h3100);
        expect_v(5, 16'h0000);
        tick();
        rd(`PWC_OFS_WAKE_1, 16'h0080);
        power_on_i = 1'b1;
        tick();
        power_on_i = 1'b0;
        rd(`PWC_OFS_WAKE_1, 16'h0000);
        // Port 2 wake sensing follows the driven level on output pins
        for (int i = 0; i < 8; i++)
        begin
            port2_pin_i = 8'($random(seed));
            port2_out_i = 8'($random(seed));
            port2_dir_out_i = 8'($random(seed));
            for (int b = 0; b < 8; b++)
            begin
                e[b] = port2_dir_out_i[b] ? port2_out_i[b] : port2_pin_i[b];
            end
            expect_v(6, {8'h00, e});
            tick();
        end
        repeat (3) tick();
        give_verdict();
    end

endmodule

`default_nettype wire
